// ---- design/opfa_regs.vh ----
// constants for the output port frame arbiter
`ifndef OPFA_REGS_VH
`define OPFA_REGS_VH

// class arbiter geometry and slot budget in lines
`define OPFA_ENTRIES     4'h9
`define OPFA_LAST_ENTRY  4'h8
`define OPFA_SLOT_LINES  8'h09
`define OPFA_CREDIT_MAX  8'h12

// class of an arbiter entry
`define OPFA_CLS_PROV    2'h0
`define OPFA_CLS_MC      2'h1
`define OPFA_CLS_ISO     2'h2
`define OPFA_CLS_ASYNC   2'h3

// path-routed class index inside the path group vector
`define OPFA_PATH_ASYNC  2'h0
`define OPFA_PATH_ISO    2'h1
`define OPFA_PATH_PROV   2'h2

// group vector sizes
`define OPFA_TURNS       8
`define OPFA_PATH_GROUPS 48
`define OPFA_MC_GROUPS   32
`define OPFA_AR_GROUPS   2

// kind of grant
`define OPFA_KIND_RESEND 2'h0
`define OPFA_KIND_PATH   2'h1
`define OPFA_KIND_MC     2'h2
`define OPFA_KIND_AR     2'h3

// address-routed group bits
`define OPFA_AR_ORDERED  0
`define OPFA_AR_BYPASSED 1

`endif

// ---- design/opfa_rr.v ----
// rotating priority arbiter, last grant lowest priority
`default_nettype none

module opfa_rr #(
  parameter N = 8,
  parameter W = 3
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [N-1:0] req,
  input  wire         advance,
  output reg          any,
  output reg  [W-1:0] idx
);

  reg [W-1:0] last;
  integer     k;
  integer     p;

  always @* begin
    any = 1'b0;
    idx = {W{1'b0}};
    p   = 0;
    // search from the entry after the last grant
    for (k = N; k >= 1; k = k - 1) begin
      p = last + k;
      if (p >= N) begin
        p = p - N;
      end
      if (req[p]) begin
        any = 1'b1;
        idx = p[W-1:0];
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      last <= {W{1'b1}};
    end else if (advance && any) begin
      last <= idx;
    end
  end

endmodule // opfa_rr

`default_nettype wire

// ---- design/opfa_arbiter.v ----
// frame arbiter for one output port and its link time slot
//
// Operation
// - nine class entries: prov, mc, prov, mc, iso, prov, mc, iso, ar/async.
// - each slot is budgeted nine lines on average.
// - with nothing pending the class pointer stays unchanged.
// - pending frames and budget left keep priority on current entry.
// - budget spent moves priority to next higher pending entry, skipping empties.
// - the search wraps from entry eight back to entry zero.
// - path-routed class picks among next turns by rotating priority.
// - the last granted turn gets lowest priority next time.
// - turn state is kept separately for each output link.
// - multicast class picks among groups by rotating priority, last lowest.
// - multicast group state is kept separately for each output link.
// - address-routed class takes no further arbitration.
// - frames without enough line credits are excluded this slot.
// - path groups are three classes times eight turns times bypassable.
// - address-routed traffic has ordered and bypassed groups.
// - resend frames win over all others and skip the arbiter.
`include "opfa_regs.vh"
`default_nettype none

module opfa_arbiter (
  input  wire        clk,
  input  wire        rst,
  input  wire [47:0] path_pend,
  input  wire [47:0] path_credit_ok,
  input  wire [31:0] mc_pend,
  input  wire [31:0] mc_credit_ok,
  input  wire [1:0]  ar_pend,
  input  wire [1:0]  ar_credit_ok,
  input  wire        resend_pend,
  input  wire        link_ready,
  input  wire        line_sent,
  input  wire        frame_end,
  output reg         grant_valid,
  output reg  [1:0]  grant_kind,
  output reg  [5:0]  grant_group,
  output reg  [3:0]  class_ptr,
  output wire        busy
);

  localparam ST_IDLE = 2'b01;
  localparam ST_SEND = 2'b10;

  reg        [1:0] state;
  reg signed [7:0] credit;

  wire [47:0] path_elig = path_pend & path_credit_ok;
  wire [31:0] mc_elig   = mc_pend & mc_credit_ok;
  wire [1:0]  ar_elig   = ar_pend & ar_credit_ok;

  wire [7:0] turn_any [0:2];
  genvar c;
  genvar t;
  generate
    for (c = 0; c < 3; c = c + 1) begin : g_cls
      for (t = 0; t < `OPFA_TURNS; t = t + 1) begin : g_turn
        assign turn_any[c][t] = path_elig[c*16 + t*2] | path_elig[c*16 + t*2 + 1];
      end
    end
  endgenerate

  wire pend_prov  = |turn_any[`OPFA_PATH_PROV];
  wire pend_iso   = |turn_any[`OPFA_PATH_ISO];
  wire pend_async = (|turn_any[`OPFA_PATH_ASYNC]) | (|ar_elig);
  wire pend_mc    = |mc_elig;

  function [1:0] entry_class;
    input [3:0] e;
    begin
      case (e)
        4'h0:    entry_class = `OPFA_CLS_PROV;
        4'h1:    entry_class = `OPFA_CLS_MC;
        4'h2:    entry_class = `OPFA_CLS_PROV;
        4'h3:    entry_class = `OPFA_CLS_MC;
        4'h4:    entry_class = `OPFA_CLS_ISO;
        4'h5:    entry_class = `OPFA_CLS_PROV;
        4'h6:    entry_class = `OPFA_CLS_MC;
        4'h7:    entry_class = `OPFA_CLS_ISO;
        default: entry_class = `OPFA_CLS_ASYNC;
      endcase
    end
  endfunction

  function cls_pend;
    input [1:0] cl;
    input       pp;
    input       pm;
    input       pi;
    input       pa;
    begin
      case (cl)
        `OPFA_CLS_PROV: cls_pend = pp;
        `OPFA_CLS_MC:   cls_pend = pm;
        `OPFA_CLS_ISO:  cls_pend = pi;
        default:        cls_pend = pa;
      endcase
    end
  endfunction

  // class entry selection
  reg     [3:0] sel_entry;
  reg           sel_found;
  reg           sel_moved;
  reg     [4:0] probe;
  integer       k;

  always @* begin
    sel_entry = class_ptr;
    sel_found = 1'b0;
    sel_moved = 1'b0;
    probe     = 5'h00;
    // hold while budget left and entry pending
    if (credit > 8'sh00 &&
        cls_pend(entry_class(class_ptr), pend_prov, pend_mc, pend_iso, pend_async)) begin
      sel_found = 1'b1;
    end else begin
      // next higher pending entry, wrap 8 to 0
      for (k = 9; k >= 1; k = k - 1) begin
        probe = {1'b0, class_ptr} + k[4:0];
        if (probe >= {1'b0, `OPFA_ENTRIES}) begin
          probe = probe - {1'b0, `OPFA_ENTRIES};
        end
        if (cls_pend(entry_class(probe[3:0]), pend_prov, pend_mc, pend_iso, pend_async)) begin
          sel_entry = probe[3:0];
          sel_found = 1'b1;
        end
      end
      sel_moved = sel_found;
    end
  end

  wire [1:0] sel_class = entry_class(sel_entry);

  // path class feeding the turn arbiter
  reg [1:0] path_cls;
  always @* begin
    case (sel_class)
      `OPFA_CLS_PROV: path_cls = `OPFA_PATH_PROV;
      `OPFA_CLS_ISO:  path_cls = `OPFA_PATH_ISO;
      default:        path_cls = `OPFA_PATH_ASYNC;
    endcase
  end

  wire       issue_ok  = (state == ST_IDLE) && link_ready;
  wire       use_ar    = (sel_class == `OPFA_CLS_ASYNC) && (|ar_elig);
  wire       use_path  = (sel_class != `OPFA_CLS_MC) && !use_ar;
  wire       arb_issue = issue_ok && !resend_pend && sel_found;
  wire       turn_any_w;
  wire [2:0] turn_idx;
  wire       mc_any_w;
  wire [4:0] mc_idx;

  // turn rotation, last turn lowest, own state per port
  opfa_rr #(
    .N (`OPFA_TURNS),
    .W (3)
  ) u_turn_rr (
    .clk     (clk),
    .rst     (rst),
    .req     (turn_any[path_cls]),
    .advance (arb_issue && use_path),
    .any     (turn_any_w),
    .idx     (turn_idx)
  );

  // multicast rotation, own state per port
  opfa_rr #(
    .N (`OPFA_MC_GROUPS),
    .W (5)
  ) u_mc_rr (
    .clk     (clk),
    .rst     (rst),
    .req     (mc_elig),
    .advance (arb_issue && (sel_class == `OPFA_CLS_MC)),
    .any     (mc_any_w),
    .idx     (mc_idx)
  );

  // ordered group of the chosen turn first, bypassable second
  wire [5:0] path_base = {path_cls, turn_idx, 1'b0};
  wire       path_byp  = !path_elig[path_base];

  // credit carried into the new slot, clamped
  wire signed [8:0] carry_sum  = $signed({credit[7], credit}) + $signed({1'b0, `OPFA_SLOT_LINES});
  wire signed [7:0] carry_next = (carry_sum > $signed({1'b0, `OPFA_CREDIT_MAX})) ?
                                 $signed(`OPFA_CREDIT_MAX) : carry_sum[7:0];
  wire              count_line = (state == ST_SEND) && line_sent &&
                                 (grant_kind != `OPFA_KIND_RESEND) && (credit != 8'sh80);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state       <= ST_IDLE;
      class_ptr   <= 4'h0;
      credit      <= `OPFA_SLOT_LINES;
      grant_valid <= 1'b0;
      grant_kind  <= `OPFA_KIND_RESEND;
      grant_group <= 6'h00;
    end else begin
      grant_valid <= 1'b0;
      case (state)
        ST_IDLE: begin
          // grant only at a frame boundary
          if (issue_ok && resend_pend) begin
            grant_valid <= 1'b1;
            grant_kind  <= `OPFA_KIND_RESEND;
            grant_group <= 6'h00;
            state       <= ST_SEND;
          end else if (arb_issue) begin
            // pointer only moves when something is pending
            class_ptr   <= sel_entry;
            if (sel_moved) begin
              credit <= carry_next;
            end
            grant_valid <= 1'b1;
            state       <= ST_SEND;
            if (sel_class == `OPFA_CLS_MC) begin
              grant_kind  <= `OPFA_KIND_MC;
              grant_group <= {1'b0, mc_idx};
            end else if (use_ar) begin
              // no further arbitration, bypassed group first
              grant_kind  <= `OPFA_KIND_AR;
              grant_group <= ar_elig[`OPFA_AR_BYPASSED] ? 6'h01 : 6'h00;
            end else begin
              grant_kind  <= `OPFA_KIND_PATH;
              grant_group <= {path_cls, turn_idx, path_byp};
            end
          end
        end
        ST_SEND: begin
          if (count_line) begin
            credit <= credit - 8'sh01;
          end
          if (frame_end) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  assign busy = (state == ST_SEND);

endmodule // opfa_arbiter

`default_nettype wire

// ---- tb/opfa_arbiter_asserts.sv ----
// port checker for the output port frame arbiter
`default_nettype none
module opfa_arbiter_asserts (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [47:0] path_pend,
  input wire logic [47:0] path_credit_ok,
  input wire logic [31:0] mc_pend,
  input wire logic [31:0] mc_credit_ok,
  input wire logic [1:0]  ar_pend,
  input wire logic [1:0]  ar_credit_ok,
  input wire logic        resend_pend,
  input wire logic        link_ready,
  input wire logic        line_sent,
  input wire logic        frame_end,
  input wire logic        grant_valid,
  input wire logic [1:0]  grant_kind,
  input wire logic [5:0]  grant_group,
  input wire logic [3:0]  class_ptr,
  input wire logic        busy
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_resend_take;
    !busy && link_ready && resend_pend;
  endsequence
  sequence s_nothing;
    !resend_pend && !(|(path_pend & path_credit_ok)) && !(|(mc_pend & mc_credit_ok))
      && !(|(ar_pend & ar_credit_ok));
  endsequence
  sequence s_arb_take;
    !busy && link_ready && !resend_pend && ((|(path_pend & path_credit_ok))
      || (|(mc_pend & mc_credit_ok)) || (|(ar_pend & ar_credit_ok)));
  endsequence
  a_take_answer: assert property (
    s_arb_take |=> grant_valid && grant_kind != 2'h0) else $error("eligible frame not granted");
  a_grant_cause: assert property (
    grant_valid |-> $past(link_ready && !busy)) else $error("grant without idle link");
  a_busy_blocks: assert property (
    busy |=> !grant_valid) else $error("grant during frame");
  a_end_release: assert property (
    busy && frame_end |=> !busy) else $error("busy after frame end");
  a_resend_wins: assert property (
    s_resend_take |=> grant_valid && grant_kind == 2'h0) else $error("resend not first");
  a_none_quiet: assert property (
    s_nothing |=> !grant_valid) else $error("grant with nothing eligible");
  a_ptr_idle: assert property (
    !grant_valid |-> $stable(class_ptr)) else $error("pointer moved without grant");
  a_resend_ptr: assert property (
    grant_valid && grant_kind == 2'h0 |-> $stable(class_ptr)) else $error("resend moved pointer");
  a_mc_entries: assert property (
    grant_valid && grant_kind == 2'h2 |-> class_ptr inside {4'h1, 4'h3, 4'h6})
    else $error("multicast off its entries");
  a_ar_entry: assert property (
    grant_valid && grant_kind == 2'h3 |-> class_ptr == 4'h8)
    else $error("address grant off entry");
endmodule // opfa_arbiter_asserts
`default_nettype wire

// ---- tb/opfa_link_partner.sv ----
// far side link model taking granted frames
`default_nettype none
module opfa_link_partner (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       grant_valid,
  input  wire logic [7:0] frame_lines,
  output var  logic       link_ready,
  output var  logic       line_sent,
  output var  logic       frame_end
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {link_ready, line_sent, frame_end} = 3'h0;
    @(negedge rst);
    link_ready <= 1'b1;
    forever begin
      do @(posedge clk); while (rst || !grant_valid);
      link_ready <= 1'b0;
      repeat (frame_lines) begin
        @(posedge clk) line_sent <= 1'b1;
        @(posedge clk) line_sent <= 1'b0;
      end
      @(posedge clk) frame_end <= 1'b1;
      @(posedge clk) frame_end <= 1'b0;
      link_ready <= 1'b1;
    end
  end
endmodule // opfa_link_partner
`default_nettype wire

// ---- tb/opfa_arbiter_bench.sv ----
// bench for the output port frame arbiter
`default_nettype none
module opfa_arbiter_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [47:0] path_pend = 48'h0;
  logic [47:0] path_credit_ok = 48'hFFFFFFFFFFFF;
  logic [31:0] mc_pend = 32'h0;
  logic [31:0] mc_credit_ok = 32'hFFFFFFFF;
  logic [1:0]  ar_pend = 2'h0;
  logic [1:0]  ar_credit_ok = 2'h3;
  logic        resend_pend = 1'b0;
  logic [7:0]  frame_lines = 8'h02;
  wire logic   link_ready, line_sent, frame_end, grant_valid, busy;
  wire logic [1:0] grant_kind;
  wire logic [5:0] grant_group;
  wire logic [3:0] class_ptr;
  int          fail_count = 0;
  int          num_checks = 0;
  always #20 clk = ~clk;
  opfa_arbiter u_opfa_arbiter (.clk(clk), .rst(rst), .path_pend(path_pend),
    .path_credit_ok(path_credit_ok), .mc_pend(mc_pend), .mc_credit_ok(mc_credit_ok),
    .ar_pend(ar_pend), .ar_credit_ok(ar_credit_ok), .resend_pend(resend_pend),
    .link_ready(link_ready), .line_sent(line_sent), .frame_end(frame_end),
    .grant_valid(grant_valid), .grant_kind(grant_kind), .grant_group(grant_group),
    .class_ptr(class_ptr), .busy(busy));
  opfa_link_partner u_opfa_link_partner (.clk(clk), .rst(rst), .grant_valid(grant_valid),
    .frame_lines(frame_lines), .link_ready(link_ready), .line_sent(line_sent),
    .frame_end(frame_end));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task final_report;
    if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // wait for one grant, compare it, then wait for its frame to end
  task do_grant(input logic [7:0] n, input logic [1:0] k, input logic [5:0] g,
                input logic [3:0] p);
    int i;
    frame_lines = n;
    for (i = 0; i < 100 && grant_valid !== 1'b1; i++) @(negedge clk);
    chk({3'h0, grant_valid, grant_kind, grant_group, class_ptr}, {3'h0, 1'b1, k, g, p});
    for (i = 0; i < 200 && busy !== 1'b0; i++) @(negedge clk);
  endtask
  task t_mc_rotate;
    mc_pend[3] = 1'b1;
    do_grant(8'h02, 2'h2, 6'h03, 4'h1);
    mc_pend[5] = 1'b1;
    do_grant(8'h02, 2'h2, 6'h05, 4'h1);
    do_grant(8'h02, 2'h2, 6'h03, 4'h1);
  endtask
  task t_resend;
    resend_pend = 1'b1;
    do_grant(8'h02, 2'h0, 6'h00, 4'h1);
  endtask
  task t_filter;
    resend_pend = 1'b0;
    mc_pend = 32'h0;
    path_credit_ok = 48'h0;
    path_pend = 48'h001100000000;
    repeat (10) begin
      @(negedge clk);
      chk(grant_valid, 16'h0);
    end
    chk(class_ptr, 16'h1);
  endtask
  task t_turn;
    path_credit_ok = 48'hFFFFFFFFFFFF;
    do_grant(8'h02, 2'h1, 6'h20, 4'h2);
    do_grant(8'h02, 2'h1, 6'h24, 4'h2);
    do_grant(8'h02, 2'h1, 6'h20, 4'h2);
  endtask
  task t_ar;
    path_pend = 48'h0;
    ar_pend = 2'h3;
    do_grant(8'h14, 2'h3, 6'h01, 4'h8);
  endtask
  task t_wrap;
    ar_pend = 2'h0;
    mc_pend[3] = 1'b1;
    path_pend[16] = 1'b1;
    do_grant(8'h14, 2'h2, 6'h03, 4'h1);
    do_grant(8'h14, 2'h2, 6'h03, 4'h3);
    do_grant(8'h02, 2'h1, 6'h10, 4'h4);
  endtask
  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk({grant_valid, grant_kind, grant_group, class_ptr, busy}, 16'h0);
    t_mc_rotate;
    t_resend;
    t_filter;
    t_turn;
    t_ar;
    t_wrap;
    final_report;
  end
  initial begin
    #400000;
    fail_count++;
    final_report;
  end
endmodule // opfa_arbiter_bench
bind opfa_arbiter opfa_arbiter_asserts u_opfa_arbiter_asserts (.clk(clk), .rst(rst),
  .path_pend(path_pend), .path_credit_ok(path_credit_ok), .mc_pend(mc_pend),
  .mc_credit_ok(mc_credit_ok), .ar_pend(ar_pend), .ar_credit_ok(ar_credit_ok),
  .resend_pend(resend_pend), .link_ready(link_ready), .line_sent(line_sent),
  .frame_end(frame_end), .grant_valid(grant_valid), .grant_kind(grant_kind),
  .grant_group(grant_group), .class_ptr(class_ptr), .busy(busy));
`default_nettype wire
